/* File: hdl/dgram_slave.sv */
// Datagram slave: on-the-fly datagram processing, ring closure and sample timing.
// Assumes byte streams with sof/eof marks, synchronous to I_SYS_CLK.
`timescale 1ns/1ps

module stream_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32,
    parameter int AFULL_MARGIN = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_afull
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rp_q];
    assign o_afull = (cnt_q >= (AW+1)'(DEPTH - AFULL_MARGIN));

    // Pointers and count; storage has no reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= i_data;
        end
    end
endmodule

module dgram_slave #(
    parameter logic [31:0] LOG_BASE = dgram_pkg::LOG_BASE_RST,
    parameter logic [31:0] SHIFT_TIME = dgram_pkg::SHIFT_TIME_RST,
    parameter logic [31:0] CALC_COPY = dgram_pkg::CALC_COPY_RST
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // Upstream receive (from master side)
    input wire logic i_UP_RX_VALID,
    input wire logic [7:0] i_UP_RX_DATA,
    input wire logic i_UP_RX_SOF,
    input wire logic i_UP_RX_EOF,
    output logic o_UP_RX_READY,
    // Upstream transmit (towards master)
    output logic o_UP_TX_VALID,
    output logic [7:0] o_UP_TX_DATA,
    output logic o_UP_TX_SOF,
    output logic o_UP_TX_EOF,
    input wire logic i_UP_TX_READY,
    // Downstream transmit and return receive
    output logic o_DN_TX_VALID,
    output logic [7:0] o_DN_TX_DATA,
    output logic o_DN_TX_SOF,
    output logic o_DN_TX_EOF,
    input wire logic i_DN_TX_READY,
    output logic o_DN_CARRIER,
    input wire logic i_DN_RX_VALID,
    input wire logic [7:0] i_DN_RX_DATA,
    input wire logic i_DN_RX_SOF,
    input wire logic i_DN_RX_EOF,
    // Link presence
    input wire logic i_UP_LINK,
    input wire logic i_DN_LINK,
    output logic o_UP_LINK,
    output logic o_DN_LINK,
    output logic o_LOOPED,
    // Sampling
    input wire logic [1:0] i_SYNC_MODE,
    input wire logic i_CFG_LOAD,
    input wire logic i_CYCLIC_RUN,
    input wire logic i_DC_SYNC,
    input wire logic [31:0] i_POSITION,
    output logic [31:0] o_IMAGE,
    output logic o_SAMPLE_STROBE,
    output logic [15:0] o_NODE_ADDR,
    output logic [31:0] o_SHIFT_TIME,
    output logic [31:0] o_CALC_COPY_TIME
);
    import dgram_pkg::*;

    typedef struct packed {
        parse_state_type st;
        logic [10:0] bcnt;
        logic [10:0] dlen;
        logic more;
        logic [7:0] cmd;
        logic [31:0] addr;
        logic sel;
        logic carry;
        logic wcarry;
        logic sm_hit;
        logic [11:0][7:0] ram;
        logic [15:0] node;
        logic [31:0] img;
        logic [31:0] pend;
        logic pend_v;
        logic strobe;
        sync_mode_type mode;
        logic [11:0] tmr;
        logic pv, psof, peof;
        logic [7:0] pd;
        logic rdy;
        logic loop, busy;
        logic up_link, dn_link;
        logic dn_v, dn_sof, dn_eof;
        logic [7:0] dn_d;
        logic up_v, up_sof, up_eof;
        logic [7:0] up_d;
    } state_type;

    state_type s_q, s_d;
    logic [1:0] rs_q;
    logic rst_n;
    logic acc, f_v, f_rdy, afull, in_rdy, pop_dn, pop_up, trig, sm_evt;
    logic is_pos, is_fix, is_log, is_rd, is_wr;
    parse_state_type cur;
    logic [10:0] b;
    logic [15:0] loff, idx;
    logic [9:0] f_data;

    // Reset release through two flops
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    // Command decode and local offset
    assign is_pos = (s_q.cmd == CMD_POS_RD) || (s_q.cmd == CMD_POS_WR);
    assign is_fix = (s_q.cmd == CMD_FIX_RD) || (s_q.cmd == CMD_FIX_WR);
    assign is_log = (s_q.cmd == CMD_LOG_RD) || (s_q.cmd == CMD_LOG_WR);
    assign is_rd = (s_q.cmd == CMD_POS_RD) || (s_q.cmd == CMD_FIX_RD) || (s_q.cmd == CMD_LOG_RD);
    assign is_wr = (s_q.cmd == CMD_POS_WR) || (s_q.cmd == CMD_FIX_WR) || (s_q.cmd == CMD_LOG_WR);
    assign loff = is_log ? {12'h000, s_q.addr[3:0]} : s_q.addr[31:16];
    assign idx = loff + {5'h00, s_q.bcnt};
    assign acc = i_UP_RX_VALID && s_q.rdy;
    // A start mark always restarts parsing at the command byte
    assign cur = (acc && i_UP_RX_SOF) ? S_HDR : s_q.st;
    assign b = (acc && i_UP_RX_SOF) ? 11'h000 : s_q.bcnt;

    // Port routing from the FIFO
    assign pop_dn = f_v && !s_q.loop && (!s_q.dn_v || i_DN_TX_READY);
    assign pop_up = f_v && s_q.loop && (!s_q.up_v || i_UP_TX_READY);
    assign f_rdy = s_q.loop ? (!s_q.up_v || i_UP_TX_READY) : (!s_q.dn_v || i_DN_TX_READY);
    assign sm_evt = acc && i_UP_RX_EOF && s_q.sm_hit;
    assign trig = (s_q.mode == M_FREE) ? (s_q.tmr == 12'(FREE_CYC - 1)) :
                  (s_q.mode == M_SMEV) ? sm_evt : i_DC_SYNC;

    // Read byte from the local map; unmapped bytes pass through
    function automatic logic [7:0] rd_byte(input state_type s, input logic [15:0] a, input logic [7:0] dflt);
        logic [7:0] r;
        r = dflt;
        if (a < IMG_BYTES) begin
            r = s.img[a[1:0]*8 +: 8];
        end else if (a < MEM_BYTES) begin
            r = s.ram[a[3:0] - 4'h4];
        end else if (a == NODE_OFS) begin
            r = s.node[7:0];
        end else if (a == NODE_OFS + 16'h0001) begin
            r = s.node[15:8];
        end
        return r;
    endfunction

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.pv = 1'b0;
        s_d.strobe = 1'b0;
        s_d.rdy = !afull;
        s_d.up_link = i_UP_LINK;
        s_d.dn_link = i_DN_LINK;
        if (acc) begin
            s_d.pv = 1'b1;
            s_d.pd = i_UP_RX_DATA;
            s_d.psof = i_UP_RX_SOF;
            s_d.peof = i_UP_RX_EOF;
            s_d.bcnt = b + 11'h001;
            s_d.st = cur;
            unique case (cur)
                S_IDLE: begin
                    s_d.bcnt = 11'h000;
                end
                S_HDR: begin
                    // address bytes captured, meaning by command
                    if (b == 11'h000) begin
                        s_d.cmd = i_UP_RX_DATA;
                        s_d.sel = 1'b0;
                        if (i_UP_RX_SOF) begin
                            s_d.sm_hit = 1'b0;
                        end
                    end else if (b >= ADDR_B0 && b <= ADDR_B3) begin
                        // Byte lane kept to two bits so the wrap from 3 to 0 stays in range
                        s_d.addr[{b[1:0] - 2'd2, 3'b000} +: 8] = i_UP_RX_DATA;
                    end else if (b == LEN_B0) begin
                        s_d.dlen[7:0] = i_UP_RX_DATA;
                    end else if (b == LEN_B1) begin
                        s_d.dlen[10:8] = i_UP_RX_DATA[2:0];
                        s_d.more = i_UP_RX_DATA[7];
                    end
                    if (is_pos && b == ADDR_B0) begin
                        s_d.pd = i_UP_RX_DATA + 8'h01;
                        s_d.carry = (i_UP_RX_DATA == 8'hff);
                    end else if (is_pos && b == ADDR_B1) begin
                        s_d.pd = i_UP_RX_DATA + {7'h00, s_q.carry};
                    end
                    if (b == SEL_B) begin
                        s_d.sel = (is_pos && s_q.addr[15:0] == 16'h0000) ||
                                  (is_fix && s_q.addr[15:0] == s_q.node) ||
                                  (is_log && s_q.addr[31:4] == LOG_BASE[31:4]);
                    end
                    if (b == HDR_LAST) begin
                        s_d.bcnt = 11'h000;
                        s_d.st = (s_q.dlen == 11'h000) ? S_WKC : S_DATA;
                    end
                end
                S_DATA: begin
                    if (s_q.sel && is_rd) begin
                        s_d.pd = rd_byte(s_q, idx, i_UP_RX_DATA);
                        if (idx < IMG_BYTES) begin
                            s_d.sm_hit = 1'b1;
                        end
                    end
                    if (s_q.sel && is_wr) begin
                        if (idx >= IMG_BYTES && idx < MEM_BYTES) begin
                            s_d.ram[idx[3:0] - 4'h4] = i_UP_RX_DATA;
                        end
                        // node address set by configuration write
                        if (idx == NODE_OFS) begin
                            s_d.node[7:0] = i_UP_RX_DATA;
                        end else if (idx == NODE_OFS + 16'h0001) begin
                            s_d.node[15:8] = i_UP_RX_DATA;
                        end
                    end
                    if (s_q.bcnt == s_q.dlen - 11'h001) begin
                        s_d.bcnt = 11'h000;
                        s_d.st = S_WKC;
                    end
                end
                S_WKC: begin
                    if (b == 11'h000) begin
                        s_d.pd = i_UP_RX_DATA + {7'h00, s_q.sel};
                        s_d.wcarry = s_q.sel && (i_UP_RX_DATA == 8'hff);
                    end else begin
                        s_d.pd = i_UP_RX_DATA + {7'h00, s_q.wcarry};
                        s_d.bcnt = 11'h000;
                        s_d.st = s_q.more ? S_HDR : S_IDLE;
                    end
                end
            endcase
            if (i_UP_RX_EOF) begin
                s_d.st = S_IDLE;
            end
        end
        if (i_CFG_LOAD && !i_CYCLIC_RUN && i_SYNC_MODE != 2'b11) begin
            s_d.mode = sync_mode_type'(i_SYNC_MODE);
        end
        s_d.tmr = (s_q.tmr == 12'(FREE_CYC - 1)) ? 12'h000 : s_q.tmr + 12'h001;
        if (s_q.pend_v && s_q.st == S_IDLE && !acc) begin
            s_d.img = s_q.pend;
            s_d.pend_v = 1'b0;
            s_d.strobe = 1'b1;
        end
        // trigger per latched mode; new sample beats commit
        if (trig) begin
            s_d.pend = i_POSITION;
            s_d.pend_v = 1'b1;
        end
        // Output holding registers drain on ready
        if (s_q.dn_v && i_DN_TX_READY) begin
            s_d.dn_v = 1'b0;
        end
        if (s_q.up_v && i_UP_TX_READY) begin
            s_d.up_v = 1'b0;
        end
        if (pop_dn) begin
            {s_d.dn_sof, s_d.dn_eof, s_d.dn_d} = f_data;
            s_d.dn_v = 1'b1;
        end
        // looped node returns processed frame upstream
        if (pop_up) begin
            {s_d.up_sof, s_d.up_eof, s_d.up_d} = f_data;
            s_d.up_v = 1'b1;
        end else if (!s_q.loop && i_DN_RX_VALID) begin
            // Return traffic from downstream is relayed without stalling
            s_d.up_d = i_DN_RX_DATA;
            s_d.up_sof = i_DN_RX_SOF;
            s_d.up_eof = i_DN_RX_EOF;
            s_d.up_v = 1'b1;
        end
        if (pop_dn || pop_up) begin
            s_d.busy = (s_q.busy || f_data[9]) && !f_data[8];
        end
        // switch only between frames, never mid-frame
        if (!s_q.busy && !(pop_dn || pop_up)) begin
            s_d.loop = !s_q.dn_link;
        end
    end

    // State register
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.node <= NODE_RST;
            s_q.loop <= 1'b1;
            s_q.mode <= M_FREE;
            s_q.st <= S_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Frame FIFO between processing and transmit; rx ready leaves slack for the stage
    stream_fifo #(.WIDTH(10), .DEPTH(32), .AFULL_MARGIN(3)) u_fifo (
        .clk(I_SYS_CLK),
        .rst_n(rst_n),
        .i_valid(s_q.pv),
        .o_ready(in_rdy),
        .i_data({s_q.psof, s_q.peof, s_q.pd}),
        .o_valid(f_v),
        .i_ready(f_rdy),
        .o_data(f_data),
        .o_afull(afull)
    );

    // hardware-only path, outputs straight from flops except the two timing parameters
    assign o_UP_RX_READY = s_q.rdy;
    assign o_UP_TX_VALID = s_q.up_v;
    assign o_UP_TX_DATA = s_q.up_d;
    assign o_UP_TX_SOF = s_q.up_sof;
    assign o_UP_TX_EOF = s_q.up_eof;
    assign o_DN_TX_VALID = s_q.dn_v;
    assign o_DN_TX_DATA = s_q.dn_d;
    assign o_DN_TX_SOF = s_q.dn_sof;
    assign o_DN_TX_EOF = s_q.dn_eof;
    assign o_DN_CARRIER = s_q.loop;
    assign o_UP_LINK = s_q.up_link;
    assign o_DN_LINK = s_q.dn_link;
    assign o_LOOPED = s_q.loop;
    assign o_IMAGE = s_q.img;
    assign o_SAMPLE_STROBE = s_q.strobe;
    assign o_NODE_ADDR = s_q.node;
    assign o_SHIFT_TIME = SHIFT_TIME;
    assign o_CALC_COPY_TIME = CALC_COPY;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    AST_POS_INC: assert property (acc && cur == S_HDR && b == ADDR_B0 && is_pos
        |=> s_q.pd == $past(i_UP_RX_DATA) + 8'h01) else $error("position not incremented");
    AST_FIX_SEL: assert property (acc && cur == S_HDR && b == SEL_B && is_fix
        |=> s_q.sel == ($past(s_q.addr[15:0]) == s_q.node)) else $error("fixed select wrong");
    AST_FREE_TRIG: assert property (s_q.mode == M_FREE && s_q.tmr == 12'(FREE_CYC - 1)
        |=> s_q.pend_v && s_q.tmr == 12'h000) else $error("free-run sample missed");
    AST_DC_CAPT: assert property (s_q.mode == M_DC && i_DC_SYNC
        |=> s_q.pend == $past(i_POSITION)) else $error("sync pulse not captured");
    AST_MODE_HOLD: assert property (i_CYCLIC_RUN |=> $stable(s_q.mode))
        else $error("mode changed during cyclic run");
    AST_ATOMIC: assert property (!$stable(s_q.img) |-> $past(s_q.st) == S_IDLE && $past(!acc))
        else $error("image changed mid-frame");
    AST_LOOP_ROUTE: assert property (s_q.loop && f_v && (!s_q.up_v || i_UP_TX_READY)
        |=> s_q.up_v && s_q.up_d == $past(f_data[7:0])) else $error("looped byte not returned upstream");
    AST_NO_DROP: assert property (s_q.pv |-> in_rdy)
        else $error("processed byte lost at fifo");
    AST_SM_EVT: assert property (s_q.mode == M_SMEV && sm_evt |=> s_q.pend_v)
        else $error("event sample missed");

    COV_LOOP: cover property (s_q.loop ##1 !s_q.loop);
    COV_SEL_READ: cover property (s_q.sel && is_rd && s_q.st == S_DATA);
    COV_COMMIT: cover property (s_q.strobe);
    COV_CHAIN: cover property (acc && s_q.st == S_WKC && s_q.more);
endmodule

/* File: hdl/dgram_pkg.sv */
// Shared constants and types for the datagram slave.
// Assumes a single 40 MHz clock; stream bytes arrive synchronous to it.
package dgram_pkg;
    // Clock and free-running sample timer
    localparam int CLK_MHZ = 40;
    localparam int FREE_PERIOD_US = 100;
    localparam int FREE_CYC = FREE_PERIOD_US * CLK_MHZ;
    // Datagram layout
    localparam logic [10:0] HDR_LAST = 11'h009;
    localparam logic [10:0] ADDR_B0 = 11'h002;
    localparam logic [10:0] ADDR_B1 = 11'h003;
    localparam logic [10:0] ADDR_B2 = 11'h004;
    localparam logic [10:0] ADDR_B3 = 11'h005;
    localparam logic [10:0] LEN_B0 = 11'h006;
    localparam logic [10:0] LEN_B1 = 11'h007;
    localparam logic [10:0] SEL_B = 11'h008;
    // Command codes
    localparam logic [7:0] CMD_POS_RD = 8'h01;
    localparam logic [7:0] CMD_POS_WR = 8'h02;
    localparam logic [7:0] CMD_FIX_RD = 8'h04;
    localparam logic [7:0] CMD_FIX_WR = 8'h05;
    localparam logic [7:0] CMD_LOG_RD = 8'h0a;
    localparam logic [7:0] CMD_LOG_WR = 8'h0b;
    // Local memory: input image bytes 0..3, general bytes 4..15
    localparam logic [15:0] IMG_BYTES = 16'h0004;
    localparam logic [15:0] MEM_BYTES = 16'h0010;
    localparam logic [15:0] NODE_OFS = 16'h0010;
    localparam logic [31:0] LOG_BASE_RST = 32'h00010000;
    localparam logic [15:0] NODE_RST = 16'h0000;
    localparam logic [31:0] SHIFT_TIME_RST = 32'h00000fa0;
    localparam logic [31:0] CALC_COPY_RST = 32'h000007d0;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_HDR = 2'b01, S_DATA = 2'b10, S_WKC = 2'b11
    } parse_state_type;
    typedef enum logic [1:0] {
        M_FREE = 2'b00, M_SMEV = 2'b01, M_DC = 2'b10
    } sync_mode_type;
endpackage

/* File: bench/ring_neighbour.sv */
// Ring neighbour: the next slave downstream, returning every byte it accepts while present.
// Assumes the slave under test drives its downstream port from the same clock.
`timescale 1ns/1ps

module ring_neighbour (
    // Clock and control
    input wire logic clk,
    input wire logic present,
    input wire logic stall,
    // Frames from the slave
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_sof,
    input wire logic tx_eof,
    output logic tx_ready,
    // Return stream and presence
    output logic link,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_sof,
    output logic rx_eof
);
    logic acc;

    assign link = present;
    assign tx_ready = !stall;
    assign acc = tx_valid && tx_ready;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5a;
    end
    always @(posedge clk) begin
        rx_valid <= present && acc;
        rx_sof <= acc && tx_sof;
        rx_eof <= acc && tx_eof;
        // Idle data toggles so a stale byte never passes for a fresh one
        rx_data <= acc ? tx_data : ~rx_data;
    end
endmodule

/* File: bench/dgram_slave_bench.sv */
// Testbench of the datagram slave: a free-run sample check, a row table of datagrams, then ring, buffer, sampling and reset cases.
// Assumes the design package and the ring neighbour model are compiled first.
`timescale 1ns/1ps

module dgram_slave_bench;
    import dgram_pkg::*;
    typedef struct packed {
        logic [7:0] cmd;
        logic [31:0] addr, data, exp_addr, exp_data;
        logic [7:0] exp_wkc;
    } row_type;
    localparam logic [31:0] POS0 = 32'h12345678;
    // Rows: command, address, data in, address out, data out, counter out
    localparam row_type ROWS [9] = '{
        '{8'h01, 32'h00000000, 32'haaaaaaaa, 32'h00000001, POS0, 8'h01},
        '{8'h01, 32'h0000fffe, 32'h55555555, 32'h0000ffff, 32'h55555555, 8'h00},
        '{8'h05, 32'h00040000, 32'hc3c30f0f, 32'h00040000, 32'hc3c30f0f, 8'h01},
        '{8'h04, 32'h00040000, 32'h00000000, 32'h00040000, 32'hc3c30f0f, 8'h01},
        '{8'h04, 32'h00040007, 32'h99999999, 32'h00040007, 32'h99999999, 8'h00},
        '{8'h0a, 32'h00010000, 32'h00000000, 32'h00010000, POS0, 8'h01},
        '{8'h0b, 32'h00020000, 32'h66666666, 32'h00020000, 32'h66666666, 8'h00},
        '{8'h02, 32'h00100000, 32'h00001234, 32'h00100001, 32'h00001234, 8'h01},
        '{8'h04, 32'h00001234, 32'h00000000, 32'h00001234, POS0, 8'h01}
    };
    logic clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0;
    logic present = 1'b1, stall = 1'b0, load = 1'b0, run = 1'b0, dc = 1'b0, up_ready = 1'b1, up_link = 1'b1;
    logic [7:0] rx_data = 8'h00;
    logic [1:0] mode = 2'b00;
    logic [31:0] pos = POS0;
    logic rx_ready, up_valid, up_sof, up_eof, dn_valid, dn_sof, dn_eof, dn_ready, carrier;
    logic ret_valid, ret_sof, ret_eof, nb_link, dn_link, looped, strobe, up_link_out, sof_seen;
    logic [7:0] up_data, dn_data, ret_data;
    logic [31:0] image, img_q, shift_t, copy_t;
    logic [15:0] node;
    logic [7:0] up_q [$];
    logic [7:0] fr [$];
    int bad_count = 0, samples_checked = 0, cyc = 0, strobes = 0, frames = 0, t0;

    dgram_slave dgram_slave_i (.I_SYS_CLK(clk), .I_RESET_N(rst_n),
        .i_UP_RX_VALID(rx_valid), .i_UP_RX_DATA(rx_data), .i_UP_RX_SOF(rx_sof), .i_UP_RX_EOF(rx_eof),
        .o_UP_RX_READY(rx_ready), .o_UP_TX_VALID(up_valid), .o_UP_TX_DATA(up_data), .o_UP_TX_SOF(up_sof),
        .o_UP_TX_EOF(up_eof), .i_UP_TX_READY(up_ready), .o_DN_TX_VALID(dn_valid), .o_DN_TX_DATA(dn_data),
        .o_DN_TX_SOF(dn_sof), .o_DN_TX_EOF(dn_eof), .i_DN_TX_READY(dn_ready), .o_DN_CARRIER(carrier),
        .i_DN_RX_VALID(ret_valid), .i_DN_RX_DATA(ret_data), .i_DN_RX_SOF(ret_sof), .i_DN_RX_EOF(ret_eof),
        .i_UP_LINK(up_link), .i_DN_LINK(nb_link), .o_UP_LINK(up_link_out), .o_DN_LINK(dn_link), .o_LOOPED(looped),
        .i_SYNC_MODE(mode), .i_CFG_LOAD(load), .i_CYCLIC_RUN(run), .i_DC_SYNC(dc), .i_POSITION(pos),
        .o_IMAGE(image), .o_SAMPLE_STROBE(strobe), .o_NODE_ADDR(node), .o_SHIFT_TIME(shift_t),
        .o_CALC_COPY_TIME(copy_t));

    ring_neighbour ring_neighbour_i (.clk(clk), .present(present), .stall(stall), .tx_valid(dn_valid),
        .tx_data(dn_data), .tx_sof(dn_sof), .tx_eof(dn_eof), .tx_ready(dn_ready), .link(nb_link),
        .rx_valid(ret_valid), .rx_data(ret_data), .rx_sof(ret_sof), .rx_eof(ret_eof));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // Collect returned bytes; counters lag one edge so readers see settled values
    always @(posedge clk) begin
        cyc <= cyc + 1;
        img_q <= image;
        if (strobe === 1'b1) strobes <= strobes + 1;
        if (up_valid === 1'b1 && up_ready === 1'b1) begin
            if (up_q.size() == 0) sof_seen = up_sof;
            up_q.push_back(up_data);
            if (up_eof === 1'b1) frames <= frames + 1;
        end
        if (rst_n === 1'b1 && image !== img_q) check(strobe, 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic add_dgram(input row_type r, input logic more);
        fr.push_back(r.cmd);
        fr.push_back(8'h00);
        for (int k = 0; k < 4; k++) fr.push_back(r.addr[8*k+:8]);
        fr.push_back(8'h04);
        fr.push_back({more, 7'h00});
        fr.push_back(8'h00);
        fr.push_back(8'h00);
        for (int k = 0; k < 4; k++) fr.push_back(r.data[8*k+:8]);
        fr.push_back(8'h00);
        fr.push_back(8'h00);
    endtask

    // Each byte is held until the edge at which ready is seen high
    task automatic send();
        up_q.delete();
        frames = 0;
        for (int i = 0; i < fr.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= fr[i];
            rx_sof <= (i == 0);
            rx_eof <= (i == fr.size() - 1);
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~rx_data;
        fr.delete();
    endtask

    task automatic wait_frame();
        int k;
        k = 0;
        while (frames < 1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        check(frames, 1);
        check(sof_seen, 1'b1);
    endtask

    task automatic check_dgram(input row_type r, input int o);
        check({up_q[o+5], up_q[o+4], up_q[o+3], up_q[o+2]}, r.exp_addr);
        check({up_q[o+13], up_q[o+12], up_q[o+11], up_q[o+10]}, r.exp_data);
        check(up_q[o+14], r.exp_wkc);
    endtask

    task automatic wait_strobe(input int n);
        int k;
        k = 0;
        while (strobes < n && k < 9000) begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog sized well beyond the expected run
    initial begin
        tick(60000);
        bad_count++;
        test_done();
    end

    initial begin
        tick(2);
        rst_n <= 1'b1;
        wait_strobe(1);
        t0 = cyc;
        wait_strobe(2);
        check(cyc - t0, FREE_CYC);
        check(image, POS0);
        $display("test free run done");
        foreach (ROWS[i]) begin
            add_dgram(ROWS[i], 1'b0);
            send();
            wait_frame();
            check(up_q.size(), 16);
            check_dgram(ROWS[i], 0);
        end
        check(node, 16'h1234);
        $display("test rows done");
        add_dgram(ROWS[0], 1'b1);
        add_dgram(ROWS[5], 1'b0);
        send();
        wait_frame();
        check(up_q.size(), 32);
        check_dgram(ROWS[0], 0);
        check_dgram(ROWS[5], 16);
        $display("test chained done");
        present <= 1'b0;
        up_link <= 1'b0;
        tick(10);
        check({looped, carrier, dn_link, up_link_out}, 4'b1100);
        add_dgram(ROWS[1], 1'b0);
        fork
            send();
            begin
                tick(6);
                up_ready <= 1'b0;
                tick(20);
                up_ready <= 1'b1;
            end
        join
        wait_frame();
        check(up_q.size(), 16);
        check_dgram(ROWS[1], 0);
        present <= 1'b1;
        up_link <= 1'b1;
        tick(10);
        check({looped, carrier, dn_link, up_link_out}, 4'b0011);
        $display("test loopback done");
        stall <= 1'b1;
        fr = '{8'h0b, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 40; k++) fr.push_back(k[7:0]);
        fr.push_back(8'h00);
        fr.push_back(8'h00);
        fork
            send();
            begin
                tick(80);
                check(rx_ready, 1'b0);
                stall <= 1'b0;
            end
        join
        wait_frame();
        check(up_q.size(), 52);
        check(up_q[49], 8'h27);
        $display("test buffer full done");
        mode <= 2'b01;
        load <= 1'b1;
        tick(1);
        run <= 1'b1;
        mode <= 2'b10;
        tick(1);
        load <= 1'b0;
        pos <= 32'h0a0b0c0d;
        tick(3);
        t0 = strobes;
        dc <= 1'b1;
        tick(1);
        dc <= 1'b0;
        tick(20);
        check(strobes - t0, 0);
        add_dgram(ROWS[0], 1'b0);
        send();
        wait_frame();
        check_dgram(ROWS[0], 0);
        tick(20);
        check(image, 32'h0a0b0c0d);
        check(strobes - t0, 1);
        $display("test input event done");
        run <= 1'b0;
        load <= 1'b1;
        tick(1);
        load <= 1'b0;
        run <= 1'b1;
        pos <= 32'h11112222;
        tick(5);
        t0 = strobes;
        dc <= 1'b1;
        tick(1);
        dc <= 1'b0;
        tick(8);
        check(image, 32'h11112222);
        check(strobes - t0, 1);
        mode <= 2'b11;
        run <= 1'b0;
        load <= 1'b1;
        tick(2);
        t0 = strobes;
        dc <= 1'b1;
        tick(1);
        dc <= 1'b0;
        load <= 1'b0;
        tick(8);
        check(strobes - t0, 1);
        $display("test sync pulse done");
        rst_n <= 1'b0;
        tick(2);
        check({looped, carrier, rx_ready, up_valid, dn_valid}, 5'b11000);
        check(image, 32'h00000000);
        check(node, 16'h0000);
        check(shift_t, SHIFT_TIME_RST);
        check(copy_t, CALC_COPY_RST);
        rst_n <= 1'b1;
        tick(4);
        check(rx_ready, 1'b1);
        $display("test reset done");
        test_done();
    end
endmodule
